// file: src/pfmms_pkg.sv
// Package of constants for the pin function mux and mode select block
package pfmms_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFS_SYS_OPT   = 8'h00;
    localparam logic [7:0] OFS_PORT_DATA = 8'h04;
    localparam logic [7:0] OFS_PORT_DIR  = 8'h08;
    localparam logic [7:0] OFS_PULL_EN   = 8'h0C;
    localparam logic [7:0] OFS_PULL_UP   = 8'h10;
    localparam logic [7:0] OFS_WAKE_EN   = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;

    // System option register fields
    localparam int SYSTEM_OPTION_REGISTER_RST_PE   = 0;
    localparam int SYSTEM_OPTION_REGISTER_DBG_PE   = 1;
    localparam int SYSTEM_OPTION_REGISTER_CMP_OUT  = 2;
    localparam int SYSTEM_OPTION_REGISTER_TIMER_EXTERNAL_CLOCK_EN  = 3;
    localparam int SYSTEM_OPTION_REGISTER_CMP_IN   = 4;
    localparam logic [4:0] SYSTEM_OPTION_REGISTER_RESET = 5'h02;

    // Status register fields
    localparam int STAT_MODE_BG  = 8;
    localparam int STAT_RST_PIN  = 9;
    localparam int STAT_DBG_ACT  = 10;

    // Pin indices
    localparam int PIN_RST = 2;
    localparam int PIN_DBG = 3;
    localparam int NPINS   = 6;
    localparam logic [5:0] PORT_RESET = 6'h00;

    // Debug link timing
    localparam int DBG_BIT_CLKS   = 16;
    localparam int SPEEDUP_NS     = 100;
    localparam int MCLK_PERIOD_NS = 50;
    localparam int SPEEDUP_CYC    =
        (SPEEDUP_NS / MCLK_PERIOD_NS) < 1 ? 1 : (SPEEDUP_NS / MCLK_PERIOD_NS);
    // Fixed clock pulses at least this many bus clocks apart
    localparam int AUX_MIN_BUS    = 2;

    typedef enum logic {MODE_RUN, MODE_BACKGROUND} pfmms_mode_t;
endpackage

// file: src/pfmms_top.sv
// Pin function mux, reset pin and mode select logic with APB registers
`timescale 1ns/1ps

// Contract
// [RQ1] After power-on reset the shared reset pin is a plain input.
// [RQ2] Setting reset pin enable turns the shared pin into active-low reset.
// [RQ3] Reset function sticks until the next power-on reset.
// [RQ4] Reset pin enable set turns on that pin's pullup.
// [RQ5] Pin driven low with reset function resets the device.
// [RQ6] During reset the debug pin is sampled as mode select.
// [RQ7] After reset the debug pin serves the debug link.
// [RQ8] Pullup on while debug pin serves debug or mode select.
// [RQ9] Debug pin is output-only port only after debug enable cleared.
// [RQ10] Debug pin high at reset release selects run mode.
// [RQ11] Debug pin held low during reset selects background mode.
// [RQ12] One debug bit spans sixteen debug controller clocks.
// [RQ13] Debug controller clock equals the bus clock.
// [RQ14] Debug link drives short high speedup pulses on rising edges.
// [RQ15] After reset other pins are inputs with pulls off.
// [RQ16] Bus clock is half the clock source rate.
// [RQ17] Fixed clock synchronised, never above half the bus clock.
// [RQ18] Reset pin: input, wakeup, timer clock, reset; never output.
// [RQ19] Debug pin: output port, comparator out, debug data, mode select.
// [RQ20] Keypad functions only act as stop or wait wakeups.
// [RQ21] Port pulls are set by software through port registers.
// [RQ22] Highest enabled function owns the pin; analog highest, port lowest.
// [RQ23] Programming voltage on reset pin disables its pulls.
// [RQ24] Pin controls follow configuration within one bus clock.
module pfmms_top (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  pin_in,
    output logic      [5:0]  pin_out,
    output logic      [5:0]  pin_oe,
    output logic      [5:0]  pin_pullup,
    output logic      [5:0]  pin_pulldown,
    input  wire logic        vpp_present,
    input  wire logic        low_power,
    input  wire logic        comparator_output,
    input  wire logic        debug_drive_low,
    input  wire logic        fixed_aux_clock,
    output logic             pin_reset_req,
    output logic             mode_background,
    output logic             debug_rx,
    output logic             debug_bit_tick,
    output logic             bus_clk_en,
    output logic             fixed_aux_en,
    output logic             timer_external_clock,
    output logic             keypad_wake
);
    // Register state
    logic [4:0]  system_option_register_reg, system_option_register_next;
    logic [5:0]  data_reg, data_next;
    logic [5:0]  dir_reg, dir_next;
    logic [5:0]  pen_reg, pen_next;
    logic [5:0]  pup_reg, pup_next;
    logic [5:0]  wake_reg, wake_next;
    logic        ready_reg, ready_next;
    logic        err_reg, err_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        wr_en;
    logic        map_hit;

    // Mode and reset state
    pfmms_pkg::pfmms_mode_t mode_reg, mode_next;
    logic        rstpin_reg, rstpin_next;
    logic        in_reset;

    // Clocking state
    logic        div_reg, div_next;
    logic [3:0]  bit_cnt_reg, bit_cnt_next;
    logic        tick_reg, tick_next;
    logic        aux_s1_reg, aux_s2_reg, aux_s3_reg;
    logic [1:0]  aux_gap_reg, aux_gap_next;
    logic        aux_en_reg, aux_en_next;

    // Debug driver state
    logic        drv_low_prev_reg;
    logic [3:0]  spd_cnt_reg, spd_cnt_next;

    // Registered pin controls
    logic [5:0]  out_reg, out_next;
    logic [5:0]  oe_reg, oe_next;
    logic [5:0]  pu_reg, pu_next;
    logic [5:0]  pd_reg, pd_next;
    logic        rx_reg, rx_next;
    logic        timer_external_clock_reg, timer_external_clock_next;
    logic        wake_out_reg, wake_out_next;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == pfmms_pkg::OFS_SYS_OPT) || (a == pfmms_pkg::OFS_PORT_DATA) ||
                    (a == pfmms_pkg::OFS_PORT_DIR) || (a == pfmms_pkg::OFS_PULL_EN) ||
                    (a == pfmms_pkg::OFS_PULL_UP) || (a == pfmms_pkg::OFS_WAKE_EN) ||
                    (a == pfmms_pkg::OFS_STATUS);
    endfunction

    // Completes on the second bus cycle, so pready can come from a flop
    assign wr_en   = psel && penable && ready_reg && pwrite && !err_reg;
    assign map_hit = is_mapped(paddr);
    // [RQ5] Pin reset feeds
    assign in_reset = srst || rstpin_reg;

    always_comb begin
        ready_next = psel && !penable;
        err_next   = psel && !penable && !map_hit;
        rdata_next = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                pfmms_pkg::OFS_SYS_OPT:   rdata_next = {27'h000_0000, system_option_register_reg};
                pfmms_pkg::OFS_PORT_DATA: rdata_next = {26'h000_0000, data_reg};
                pfmms_pkg::OFS_PORT_DIR:  rdata_next = {26'h000_0000, dir_reg};
                pfmms_pkg::OFS_PULL_EN:   rdata_next = {26'h000_0000, pen_reg};
                pfmms_pkg::OFS_PULL_UP:   rdata_next = {26'h000_0000, pup_reg};
                pfmms_pkg::OFS_WAKE_EN:   rdata_next = {26'h000_0000, wake_reg};
                pfmms_pkg::OFS_STATUS: begin
                    rdata_next = {26'h000_0000, pin_in};
                    rdata_next[pfmms_pkg::STAT_MODE_BG] = (mode_reg == pfmms_pkg::MODE_BACKGROUND);
                    rdata_next[pfmms_pkg::STAT_RST_PIN] = system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_RST_PE];
                    rdata_next[pfmms_pkg::STAT_DBG_ACT] = system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_DBG_PE];
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        system_option_register_next = system_option_register_reg;
        data_next = data_reg;
        dir_next  = dir_reg;
        pen_next  = pen_reg;
        pup_next  = pup_reg;
        wake_next = wake_reg;
        if (wr_en) begin
            unique case (paddr)
                pfmms_pkg::OFS_SYS_OPT: begin
                    system_option_register_next = pwdata[4:0];
                    // [RQ3] Reset function sticky
                    system_option_register_next[pfmms_pkg::SYSTEM_OPTION_REGISTER_RST_PE] = system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_RST_PE]
                                                        | pwdata[pfmms_pkg::SYSTEM_OPTION_REGISTER_RST_PE];
                end
                pfmms_pkg::OFS_PORT_DATA: data_next = pwdata[5:0];
                pfmms_pkg::OFS_PORT_DIR:  dir_next  = pwdata[5:0];
                // [RQ21] Software pull control
                pfmms_pkg::OFS_PULL_EN:   pen_next  = pwdata[5:0];
                pfmms_pkg::OFS_PULL_UP:   pup_next  = pwdata[5:0];
                pfmms_pkg::OFS_WAKE_EN:   wake_next = pwdata[5:0];
                default: system_option_register_next = system_option_register_reg;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            // [RQ1] Reset pin starts as input
            system_option_register_reg  <= pfmms_pkg::SYSTEM_OPTION_REGISTER_RESET;
            // [RQ15] Ports start high-Z, pulls off
            data_reg  <= pfmms_pkg::PORT_RESET;
            dir_reg   <= pfmms_pkg::PORT_RESET;
            pen_reg   <= pfmms_pkg::PORT_RESET;
            pup_reg   <= pfmms_pkg::PORT_RESET;
            wake_reg  <= pfmms_pkg::PORT_RESET;
        end else begin
            ready_reg <= ready_next;
            err_reg   <= err_next;
            rdata_reg <= rdata_next;
            system_option_register_reg  <= system_option_register_next;
            data_reg  <= data_next;
            dir_reg   <= dir_next;
            pen_reg   <= pen_next;
            pup_reg   <= pup_next;
            wake_reg  <= wake_next;
        end
    end

    // Mode select and pin reset
    always_comb begin
        mode_next   = mode_reg;
        // [RQ2] Pin low means reset once enabled
        rstpin_next = system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_RST_PE] && !pin_in[pfmms_pkg::PIN_RST];
        // [RQ6] Sample mode pin in reset
        if (in_reset) begin
            // [RQ10] High selects run
            // [RQ11] Low selects background
            mode_next = pin_in[pfmms_pkg::PIN_DBG] ? pfmms_pkg::MODE_RUN
                                                   : pfmms_pkg::MODE_BACKGROUND;
        end
    end

    // Mode flop has no reset branch: it is loaded from the pin during reset
    always_ff @(posedge mclk) begin
        mode_reg <= mode_next;
        if (srst) begin
            rstpin_reg <= 1'b0;
        end else begin
            rstpin_reg <= rstpin_next;
        end
    end

    // Clock enables
    always_comb begin
        // [RQ16] Bus clock at half rate
        div_next     = !div_reg;
        bit_cnt_next = bit_cnt_reg;
        tick_next    = 1'b0;
        // [RQ13] Debug clock is bus clock
        if (div_reg) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
            // [RQ12] Sixteen clocks per bit
            tick_next    = (bit_cnt_reg == 4'(pfmms_pkg::DBG_BIT_CLKS - 1));
        end
        aux_gap_next = aux_gap_reg;
        aux_en_next  = 1'b0;
        if (div_reg) begin
            if (aux_gap_reg != 2'h0) begin
                aux_gap_next = aux_gap_reg - 2'h1;
            end
            // [RQ17] Synced edge, rate limited
            if (aux_s2_reg && !aux_s3_reg && aux_gap_reg == 2'h0) begin
                aux_en_next  = 1'b1;
                aux_gap_next = 2'(pfmms_pkg::AUX_MIN_BUS - 1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_reg     <= 1'b0;
            bit_cnt_reg <= 4'h0;
            tick_reg    <= 1'b0;
            aux_s1_reg  <= 1'b0;
            aux_s2_reg  <= 1'b0;
            aux_s3_reg  <= 1'b0;
            aux_gap_reg <= 2'h0;
            aux_en_reg  <= 1'b0;
        end else begin
            div_reg     <= div_next;
            bit_cnt_reg <= bit_cnt_next;
            tick_reg    <= tick_next;
            aux_s1_reg  <= fixed_aux_clock;
            aux_s2_reg  <= aux_s1_reg;
            // Edge history only advances on the bus clock
            if (div_reg) begin
                aux_s3_reg <= aux_s2_reg;
            end
            aux_gap_reg <= aux_gap_next;
            aux_en_reg  <= aux_en_next;
        end
    end

    // Debug line speedup timer
    always_comb begin
        spd_cnt_next = (spd_cnt_reg != 4'h0) ? spd_cnt_reg - 4'h1 : 4'h0;
        // [RQ14] Speedup pulse on release
        if (drv_low_prev_reg && !debug_drive_low) begin
            spd_cnt_next = 4'(pfmms_pkg::SPEEDUP_CYC);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            drv_low_prev_reg <= 1'b0;
            spd_cnt_reg      <= 4'h0;
        end else begin
            drv_low_prev_reg <= debug_drive_low;
            spd_cnt_reg      <= spd_cnt_next;
        end
    end

    // Pin function resolution, registered for glitch-free pads
    always_comb begin
        logic dbg_pe;
        logic cmp_in;
        dbg_pe = system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_DBG_PE];
        cmp_in = system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_CMP_IN];
        // [RQ22] Start from port, then override upward
        out_next = data_reg;
        oe_next  = dir_reg;
        pu_next  = pen_reg & pup_reg;
        pd_next  = pen_reg & ~pup_reg;
        // Comparator inputs own pins 0 and 1
        if (cmp_in) begin
            oe_next[1:0] = 2'b00;
            pu_next[1:0] = 2'b00;
            pd_next[1:0] = 2'b00;
        end
        // [RQ18] Reset pin never drives
        out_next[pfmms_pkg::PIN_RST] = 1'b0;
        oe_next[pfmms_pkg::PIN_RST]  = 1'b0;
        // [RQ4] Pullup with reset function
        if (system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_RST_PE]) begin
            pu_next[pfmms_pkg::PIN_RST] = 1'b1;
            pd_next[pfmms_pkg::PIN_RST] = 1'b0;
        end
        // [RQ23] Programming voltage kills pulls
        if (vpp_present) begin
            pu_next[pfmms_pkg::PIN_RST] = 1'b0;
            pd_next[pfmms_pkg::PIN_RST] = 1'b0;
        end
        // [RQ19] Debug pin priority chain
        // [RQ9] Port output only when debug off
        out_next[pfmms_pkg::PIN_DBG] = data_reg[pfmms_pkg::PIN_DBG];
        oe_next[pfmms_pkg::PIN_DBG]  = 1'b1;
        pu_next[pfmms_pkg::PIN_DBG]  = 1'b0;
        pd_next[pfmms_pkg::PIN_DBG]  = 1'b0;
        if (system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_CMP_OUT]) begin
            out_next[pfmms_pkg::PIN_DBG] = comparator_output;
        end
        if (dbg_pe || in_reset) begin
            // [RQ8] Pullup for debug and mode select
            pu_next[pfmms_pkg::PIN_DBG]  = 1'b1;
            // [RQ7] Pseudo open-drain debug driver
            out_next[pfmms_pkg::PIN_DBG] = (spd_cnt_reg != 4'h0);
            oe_next[pfmms_pkg::PIN_DBG]  = !in_reset && (debug_drive_low || spd_cnt_reg != 4'h0);
        end
        // [RQ15] Power-on reset (srst) holds pads released; pin reset does not
        if (in_reset && srst) begin
            oe_next = 6'h00;
            pu_next = 6'h00;
            pd_next = 6'h00;
            pu_next[pfmms_pkg::PIN_DBG] = 1'b1;
        end
        rx_next   = (dbg_pe && !in_reset) ? pin_in[pfmms_pkg::PIN_DBG] : 1'b1;
        timer_external_clock_next = system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_TIMER_EXTERNAL_CLOCK_EN] && !system_option_register_reg[pfmms_pkg::SYSTEM_OPTION_REGISTER_RST_PE]
                    && pin_in[pfmms_pkg::PIN_RST];
        // [RQ20] Keypad only wakes from low power
        wake_out_next = low_power && |(wake_reg & ~pin_in & ~oe_reg);
    end

    // [RQ24] Controls registered within one cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_reg      <= 6'h00;
            oe_reg       <= 6'h00;
            // [RQ8] Mode select pullup held in reset
            pu_reg       <= 6'(1 << pfmms_pkg::PIN_DBG);
            pd_reg       <= 6'h00;
            rx_reg       <= 1'b1;
            timer_external_clock_reg     <= 1'b0;
            wake_out_reg <= 1'b0;
        end else begin
            out_reg      <= out_next;
            oe_reg       <= oe_next;
            pu_reg       <= pu_next;
            pd_reg       <= pd_next;
            rx_reg       <= rx_next;
            timer_external_clock_reg     <= timer_external_clock_next;
            wake_out_reg <= wake_out_next;
        end
    end

    assign prdata               = rdata_reg;
    assign pready               = ready_reg;
    assign pslverr              = err_reg;
    assign pin_out              = out_reg;
    assign pin_oe               = oe_reg;
    assign pin_pullup           = pu_reg;
    assign pin_pulldown         = pd_reg;
    assign pin_reset_req        = rstpin_reg;
    assign mode_background      = (mode_reg == pfmms_pkg::MODE_BACKGROUND);
    assign debug_rx             = rx_reg;
    assign debug_bit_tick       = tick_reg;
    assign bus_clk_en           = div_reg;
    assign fixed_aux_en         = aux_en_reg;
    assign timer_external_clock = timer_external_clock_reg;
    assign keypad_wake          = wake_out_reg;
endmodule

// file: dv/pfmms_assertions.sv
// Assertion checker for the pin mux and mode select block
`timescale 1ns/1ps
module pfmms_checker (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic [5:0] pin_in,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] pin_pullup,
    input wire logic [5:0] pin_pulldown,
    input wire logic       vpp_present,
    input wire logic       debug_drive_low,
    input wire logic       pin_reset_req,
    input wire logic       mode_background,
    input wire logic       debug_bit_tick,
    input wire logic       bus_clk_en,
    input wire logic       fixed_aux_en
);
    logic [5:0] gap_reg;
    logic [5:0] gap_next;
    logic       seen_reg;
    logic       seen_next;

    // Counts clocks between bit ticks; first tick only arms it
    always_comb begin
        gap_next  = debug_bit_tick ? 6'h00 : gap_reg + 6'h01;
        seen_next = seen_reg | debug_bit_tick;
        if (srst) begin
            gap_next  = 6'h00;
            seen_next = 1'h0;
        end
    end
    always_ff @(posedge mclk) begin
        gap_reg  <= gap_next;
        seen_reg <= seen_next;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_reset_pins: assert property ($fell(srst) |->
        pin_oe == 6'h00 && pin_pullup == 6'h08 && pin_pulldown == 6'h00)
        else $error("pin controls wrong after reset");
    a_mode_pick: assert property ($fell(srst) |->
        mode_background == !$past(pin_in[3])) else $error("mode not sampled from pin");
    a_mode_hold: assert property (!pin_reset_req && !$past(pin_reset_req) &&
        !$past(pin_reset_req, 2) && !$past(srst) |-> $stable(mode_background))
        else $error("mode changed outside reset");
    a_rst_no_drive: assert property (!pin_oe[2]) else $error("reset pin driven");
    a_rst_cause: assert property (pin_reset_req |-> !$past(pin_in[2]))
        else $error("pin reset without low pin");
    a_rst_pullup: assert property (pin_reset_req && !vpp_present &&
        !$past(vpp_present) |-> pin_pullup[2]) else $error("reset pin pullup off");
    a_vpp_pulls: assert property (vpp_present && $past(vpp_present) |->
        !pin_pullup[2] && !pin_pulldown[2]) else $error("pulls on with vpp");
    a_dbg_low: assert property (debug_drive_low && pin_pullup[3] |=>
        pin_oe[3] && !pin_out[3]) else $error("debug pin not driven low");
    a_speedup_high: assert property ($fell(debug_drive_low) && pin_pullup[3] |->
        ##[1:2] (pin_oe[3] && pin_out[3])) else $error("no speedup pulse");
    a_speedup_end: assert property ($fell(debug_drive_low) && pin_pullup[3] |->
        ##[3:4] !pin_oe[3]) else $error("speedup pulse too long");
    a_bit_period: assert property (debug_bit_tick && seen_reg |-> gap_reg == 6'h1f)
        else $error("debug bit period wrong");
    a_bus_half: assert property (bus_clk_en |=> !bus_clk_en)
        else $error("bus clock enable not half rate");
    a_aux_gap: assert property (fixed_aux_en |=> !fixed_aux_en [*3])
        else $error("aux clock pulses too close");

    c_pin_reset: cover property (pin_reset_req);
    c_speedup: cover property ($fell(debug_drive_low) && pin_pullup[3]);
    c_background: cover property (mode_background);
endmodule

bind pfmms_top pfmms_checker pfmms_checker_i (.mclk, .srst, .pin_in, .pin_out, .pin_oe,
    .pin_pullup, .pin_pulldown, .vpp_present, .debug_drive_low, .pin_reset_req,
    .mode_background, .debug_bit_tick, .bus_clk_en, .fixed_aux_en);

// file: dv/pfmms_board.sv
// Board model: external drivers, pulls and debug host on the pads
`timescale 1ns/1ps
module pfmms_board (
    input  wire logic       mclk,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] pin_pullup,
    input  wire logic [5:0] pin_pulldown,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    input  wire logic       host_low,
    output logic      [5:0] pin_in
);
    logic [5:0] flt_reg = 6'h15;

    // Undriven pads wander so a stale level never passes
    always @(posedge mclk) flt_reg <= ~pin_in;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pullup[i]) pin_in[i] = 1'h1;
            else if (pin_pulldown[i]) pin_in[i] = 1'h0;
            else pin_in[i] = flt_reg[i];
        end
        if (host_low) pin_in[3] = 1'h0;
    end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the pin mux and mode select block
`timescale 1ns/1ps
module testbench;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [5:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, ext_en, ext_val;
    logic        vpp_present, low_power, comparator_output, debug_drive_low;
    logic        fixed_aux_clock, pin_reset_req, mode_background, debug_rx, host_low;
    logic        debug_bit_tick, bus_clk_en, fixed_aux_en, timer_external_clock, keypad_wake;
    logic [5:0]  en, up, dat, dir;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    pfmms_top pfmms_top_i (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown,
        .vpp_present, .low_power, .comparator_output, .debug_drive_low, .fixed_aux_clock,
        .pin_reset_req, .mode_background, .debug_rx, .debug_bit_tick, .bus_clk_en,
        .fixed_aux_en, .timer_external_clock, .keypad_wake);
    pfmms_board pfmms_board_i (.mclk, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown,
        .ext_en, .ext_val, .host_low, .pin_in);

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        fixed_aux_clock <= cyc[2];
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                      input logic e);
        apb(1'h0, a, 32'h0000_0000);
        chk(rdat & m, exp);
        chk(rerr, e);
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask

    task automatic por();
        srst <= 1'h1;
        repeat (6) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
    endtask

    initial begin
        srst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        vpp_present = 1'h0;
        low_power = 1'h0;
        comparator_output = 1'h0;
        debug_drive_low = 1'h0;
        ext_en = 6'h00;
        ext_val = 6'h00;
        host_low = 1'h0;
        void'($urandom(9578));
        por();
        chk(pin_oe, 32'h0000_0000);
        chk(pin_pullup, 32'h0000_0008);
        chk(mode_background, 32'h0000_0000);
        rd(pfmms_pkg::OFS_SYS_OPT, 32'hffff_ffff, 32'h0000_0002, 1'h0);
        rd(pfmms_pkg::OFS_STATUS, 32'h0000_0700, 32'h0000_0400, 1'h0);
        rd(8'h1c, 32'hffff_ffff, 32'h0000_0000, 1'h1);
        host_low <= 1'h1;
        settle();
        chk(debug_rx, 32'h0000_0000);
        host_low <= 1'h0;
        settle();
        chk(debug_rx, 32'h0000_0001);
        repeat (4) begin
            en = 6'($urandom);
            up = 6'($urandom);
            dat = 6'($urandom);
            dir = 6'($urandom);
            wr(pfmms_pkg::OFS_PULL_EN, 32'(en));
            wr(pfmms_pkg::OFS_PULL_UP, 32'(up));
            wr(pfmms_pkg::OFS_PORT_DATA, 32'(dat));
            wr(pfmms_pkg::OFS_PORT_DIR, 32'h0000_0000);
            settle();
            chk(pin_pullup & 6'h37, en & up & 6'h37);
            chk(pin_pulldown & 6'h37, en & ~up & 6'h37);
            wr(pfmms_pkg::OFS_PORT_DIR, 32'(dir));
            settle();
            chk(pin_oe, dir & 6'h33);
            chk(pin_out & dir & 6'h33, dat & dir & 6'h33);
        end
        wr(pfmms_pkg::OFS_PULL_EN, 32'h0000_003f);
        wr(pfmms_pkg::OFS_PORT_DIR, 32'h0000_003f);
        settle();
        chk(pin_oe[1:0], 32'h0000_0003);
        wr(pfmms_pkg::OFS_SYS_OPT, 32'h0000_0012);
        settle();
        chk({pin_oe[1:0], pin_pullup[1:0], pin_pulldown[1:0]}, 32'h0000_0000);
        wr(pfmms_pkg::OFS_PULL_EN, 32'h0000_0000);
        wr(pfmms_pkg::OFS_PORT_DIR, 32'h0000_0000);
        wr(pfmms_pkg::OFS_SYS_OPT, 32'h0000_000a);
        ext_en <= 6'h05;
        for (int v = 0; v < 2; v++) begin
            ext_val <= 6'(v * 5);
            settle();
            chk(timer_external_clock, 32'(v));
        end
        wr(pfmms_pkg::OFS_WAKE_EN, 32'h0000_0001);
        low_power <= 1'h1;
        ext_val <= 6'h04;
        settle();
        chk(keypad_wake, 32'h0000_0001);
        low_power <= 1'h0;
        settle();
        chk(keypad_wake, 32'h0000_0000);
        wr(pfmms_pkg::OFS_SYS_OPT, 32'h0000_000b);
        settle();
        chk(pin_pullup[2], 32'h0000_0001);
        chk(timer_external_clock, 32'h0000_0000);
        wr(pfmms_pkg::OFS_SYS_OPT, 32'h0000_0002);
        rd(pfmms_pkg::OFS_STATUS, 32'h0000_0200, 32'h0000_0200, 1'h0);
        vpp_present <= 1'h1;
        settle();
        chk({pin_pullup[2], pin_pulldown[2]}, 32'h0000_0000);
        vpp_present <= 1'h0;
        host_low <= 1'h1;
        ext_val <= 6'h00;
        settle();
        chk(pin_reset_req, 32'h0000_0001);
        ext_val <= 6'h04;
        settle();
        host_low <= 1'h0;
        settle();
        chk(pin_reset_req, 32'h0000_0000);
        chk(mode_background, 32'h0000_0001);
        debug_drive_low <= 1'h1;
        @(posedge mclk);
        debug_drive_low <= 1'h0;
        repeat (6) @(posedge mclk);
        chk(pin_oe[3], 32'h0000_0000);
        wr(pfmms_pkg::OFS_PORT_DATA, 32'h0000_0008);
        wr(pfmms_pkg::OFS_SYS_OPT, 32'h0000_0001);
        settle();
        chk({pin_oe[3], pin_out[3], pin_pullup[3]}, 32'h0000_0006);
        wr(pfmms_pkg::OFS_SYS_OPT, 32'h0000_0005);
        for (int v = 0; v < 2; v++) begin
            comparator_output <= 1'(v);
            settle();
            chk(pin_out[3], 32'(v));
        end
        por();
        chk(mode_background, 32'h0000_0000);
        rd(pfmms_pkg::OFS_STATUS, 32'h0000_0700, 32'h0000_0400, 1'h0);
        end_of_test();
    end
endmodule
